// ===== dpb_defs.svh
`ifndef DPB_DEFS_SVH
`define DPB_DEFS_SVH

// latencies in ck cycles
`define DPB_READ_LAT      5
`define DPB_WRITE_LAT     5

// burst lengths in beats
`define DPB_BL8           4'h8
`define DPB_BC4           4'h4

// storage depth as address bits
`define DPB_MEM_AW        6

// pin widths
`define DPB_DQ_W          8
`define DPB_ADDR_W        15
`define DPB_BA_W          3

// lanes in use per width
`define DPB_LANES_X8      8'hFF
`define DPB_LANES_X4      8'h0F

// mode register selects on bank address
`define DPB_MR0_SEL       3'h0
`define DPB_MR1_SEL       3'h1

// mode register 0 burst field and its codes
`define DPB_MR0_BL_LO     0
`define DPB_MR0_BL_HI     1
`define DPB_BL_FIX8       2'h0
`define DPB_BL_OTF        2'h1
`define DPB_BL_FIX4       2'h2

// mode register 1 termination and strobe fields
`define DPB_MR1_RTT_A     2
`define DPB_MR1_RTT_B     6
`define DPB_MR1_RTT_C     9
`define DPB_MR1_TDQS      11

// on-the-fly burst chop address bit
`define DPB_A_BC          12

`endif

// ===== dpb_pkg.sv
package dpb_pkg;

  // command on {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    cmd_mrs   = 4'b0000,
    cmd_ref   = 4'b0001,
    cmd_pre   = 4'b0010,
    cmd_act   = 4'b0011,
    cmd_wr    = 4'b0100,
    cmd_rd    = 4'b0101,
    cmd_zq    = 4'b0110,
    cmd_nop   = 4'b0111,
    cmd_desel = 4'b1000
  } dpb_cmd_t;

  typedef enum logic [2:0] {
    st_idle    = 3'b000,
    st_wr_wait = 3'b001,
    st_wr_data = 3'b010,
    st_rd_wait = 3'b011,
    st_rd_data = 3'b100
  } dpb_state_t;

  // control and address pins
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        odt;
    logic [2:0]  ba;
    logic [14:0] addr;
  } dpb_ca_t;

  // every pin sampled from the link side
  typedef struct packed {
    dpb_ca_t     ca;
    logic        ck;
    logic        dqs;
    logic        dm;
    logic [7:0]  dq;
  } dpb_pin_t;

endpackage

// ===== dpb_sync.sv
`timescale 1ns/100ps
module dpb_sync #(
  parameter int unsigned W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // raw and filtered
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit changes once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge ref_clk)
      begin
        if (reset)
          q[i] <= INIT[i];
        else if (s2[i] == s3[i])
          q[i] <= s3[i];
      end
    end
  endgenerate

endmodule

// ===== dpb_cmd_dec.sv
`timescale 1ns/100ps
module dpb_cmd_dec (
  // sampled pins
  input  wire dpb_pkg::dpb_ca_t ca,
  // decoded command
  output dpb_pkg::dpb_cmd_t     cmd
);

  function automatic dpb_pkg::dpb_cmd_t decode(input dpb_pkg::dpb_ca_t c);
    dpb_pkg::dpb_cmd_t r;
    r = dpb_pkg::cmd_desel;
    if (!c.cs_n)
    begin
      case ({c.ras_n, c.cas_n, c.we_n})
        3'b000:  r = dpb_pkg::cmd_mrs;
        3'b001:  r = dpb_pkg::cmd_ref;
        3'b010:  r = dpb_pkg::cmd_pre;
        3'b011:  r = dpb_pkg::cmd_act;
        3'b100:  r = dpb_pkg::cmd_wr;
        3'b101:  r = dpb_pkg::cmd_rd;
        3'b110:  r = dpb_pkg::cmd_zq;
        default: r = dpb_pkg::cmd_nop;
      endcase
    end
    return r;
  endfunction

  always_comb
  begin
    cmd = decode(ca);
  end

endmodule

// ===== dpb_ddr3_pins.sv
`timescale 1ns/100ps
`include "dpb_defs.svh"
// Operation
// - masked write beats are not stored
// - x8 strobe termination disables data mask
// - registered odt switches internal termination
// - terminate only data, strobe, mask balls, plus term_tdqs_n when strobe termination is on
// - termination off in mode ignores odt
// - command decoded from four select inputs
// - reset pin acts asynchronously, active low
// - read strobe edges align with data
// - bidirectional data, eight or four lanes
// - spare balls become upper lanes on x8
// - chip select high ignores command
// - inputs sampled on rising clock crossing
module dpb_ddr3_pins #(
  parameter bit          X8_MODE   = 1'b1,
  parameter int unsigned READ_LAT  = `DPB_READ_LAT,
  parameter int unsigned WRITE_LAT = `DPB_WRITE_LAT,
  parameter int unsigned MEM_AW    = `DPB_MEM_AW
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        rst_n,
  // link clock
  input  wire logic        ck,
  // command and address
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic        odt,
  input  wire logic [2:0]  ba,
  input  wire logic [14:0] addr,
  // data lanes
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  output logic      [7:0]  dq_oe,
  input  wire logic        dm_in,
  // data strobe
  input  wire logic        dqs_in,
  output logic             dqs_out,
  output logic             dqs_n_out,
  output logic             dqs_oe,
  // termination enables
  output logic      [7:0]  term_dq,
  output logic             term_dqs,
  output logic             term_dm,
  output logic             term_tdqs_n
);

  localparam logic [3:0] RL_M1 = 4'(READ_LAT - 1);
  localparam logic [3:0] WL_M1 = 4'(WRITE_LAT - 1);
  localparam logic [7:0] LANES =
    X8_MODE ? `DPB_LANES_X8 : `DPB_LANES_X4;
  localparam dpb_pkg::dpb_pin_t PIN_INIT = '{
    ca: '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
          odt: 1'b0, ba: 3'h0, addr: 15'h0000},
    ck: 1'b0, dqs: 1'b0, dm: 1'b0, dq: 8'h00};

  dpb_pkg::dpb_pin_t   pin_raw;
  dpb_pkg::dpb_pin_t   pin;
  dpb_pkg::dpb_cmd_t   cmd;
  dpb_pkg::dpb_state_t state;

  logic              ck_prev;
  logic              dqs_prev;
  logic              ck_rise;
  logic              ck_edge;
  logic              dqs_edge;
  logic [1:0]        bl_mode;
  logic              rtt_en;
  logic              tdqs_en;
  logic              odt_reg;
  logic [3:0]        lat_cnt;
  logic [3:0]        beat_cnt;
  logic [3:0]        beat_total;
  logic [MEM_AW-1:0] col_base;
  logic [MEM_AW-1:0] mem_idx;
  logic [7:0]        mem [2**MEM_AW];
  logic              rd_start;
  logic              rd_step;
  logic              rd_end;
  logic              wr_beat;
  logic              wr_keep;
  logic              term_on;

  // burst length of a read or write command
  function automatic logic [3:0] burst_len(input logic [1:0] mode,
                                           input logic       a_bc);
    logic [3:0] r;
    r = `DPB_BL8;
    case (mode)
      `DPB_BL_FIX8: r = `DPB_BL8;
      `DPB_BL_OTF:  r = a_bc ? `DPB_BL8 : `DPB_BC4;
      `DPB_BL_FIX4: r = `DPB_BC4;
      default:      r = `DPB_BL8;
    endcase
    return r;
  endfunction

  // pins cross into ref_clk through three stages
  assign pin_raw.ca.cs_n  = cs_n;
  assign pin_raw.ca.ras_n = ras_n;
  assign pin_raw.ca.cas_n = cas_n;
  assign pin_raw.ca.we_n  = we_n;
  assign pin_raw.ca.odt   = odt;
  assign pin_raw.ca.ba    = ba;
  assign pin_raw.ca.addr  = addr;
  assign pin_raw.ck       = ck;
  assign pin_raw.dqs      = dqs_in;
  assign pin_raw.dm       = dm_in;
  assign pin_raw.dq       = dq_in;

  dpb_sync #(
    .W    ($bits(dpb_pkg::dpb_pin_t)),
    .INIT (PIN_INIT)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .d       (pin_raw),
    .q       (pin)
  );

  dpb_cmd_dec u_dec (
    .ca  (pin.ca),
    .cmd (cmd)
  );

  // link clock and strobe edges
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ck_prev  <= 1'b0;
      dqs_prev <= 1'b0;
    end
    else if (reset)
    begin
      ck_prev  <= 1'b0;
      dqs_prev <= 1'b0;
    end
    else
    begin
      ck_prev  <= pin.ck;
      dqs_prev <= pin.dqs;
    end
  end

  assign ck_rise  = pin.ck & ~ck_prev;
  assign ck_edge  = pin.ck ^ ck_prev;
  assign dqs_edge = pin.dqs ^ dqs_prev;

  // mode registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bl_mode <= `DPB_BL_FIX8;
      rtt_en  <= 1'b0;
      tdqs_en <= 1'b0;
    end
    else if (reset)
    begin
      bl_mode <= `DPB_BL_FIX8;
      rtt_en  <= 1'b0;
      tdqs_en <= 1'b0;
    end
    else if (ck_rise && cmd == dpb_pkg::cmd_mrs && state == dpb_pkg::st_idle)
    begin
      if (pin.ca.ba == `DPB_MR0_SEL)
        bl_mode <= pin.ca.addr[`DPB_MR0_BL_HI:`DPB_MR0_BL_LO];
      if (pin.ca.ba == `DPB_MR1_SEL)
      begin
        rtt_en  <= pin.ca.addr[`DPB_MR1_RTT_A] |
                   pin.ca.addr[`DPB_MR1_RTT_B] |
                   pin.ca.addr[`DPB_MR1_RTT_C];
        tdqs_en <= pin.ca.addr[`DPB_MR1_TDQS] & X8_MODE;
      end
    end
  end

  // termination request registered on the clock crossing
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      odt_reg <= 1'b0;
    else if (reset)
      odt_reg <= 1'b0;
    else if (!rtt_en)
      odt_reg <= 1'b0;
    else if (ck_rise)
      odt_reg <= pin.ca.odt;
  end

  assign rd_start = state == dpb_pkg::st_rd_wait && ck_rise && lat_cnt == 4'h0;
  assign rd_step  = state == dpb_pkg::st_rd_data && ck_edge &&
                    beat_cnt != beat_total;
  assign rd_end   = state == dpb_pkg::st_rd_data && ck_edge &&
                    beat_cnt == beat_total;
  assign wr_beat  = state == dpb_pkg::st_wr_data && dqs_edge;
  assign mem_idx  = col_base + MEM_AW'(beat_cnt);

  // sequencer
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= dpb_pkg::st_idle;
      lat_cnt    <= 4'h0;
      beat_cnt   <= 4'h0;
      beat_total <= `DPB_BL8;
      col_base   <= '0;
    end
    else if (reset)
    begin
      state      <= dpb_pkg::st_idle;
      lat_cnt    <= 4'h0;
      beat_cnt   <= 4'h0;
      beat_total <= `DPB_BL8;
      col_base   <= '0;
    end
    else
    begin
      case (state)
        dpb_pkg::st_idle:
          if (ck_rise && (cmd == dpb_pkg::cmd_wr || cmd == dpb_pkg::cmd_rd))
          begin
            beat_cnt   <= 4'h0;
            beat_total <= burst_len(bl_mode, pin.ca.addr[`DPB_A_BC]);
            col_base   <= pin.ca.addr[MEM_AW-1:0];
            if (cmd == dpb_pkg::cmd_wr)
            begin
              state   <= dpb_pkg::st_wr_wait;
              lat_cnt <= WL_M1;
            end
            else
            begin
              state   <= dpb_pkg::st_rd_wait;
              lat_cnt <= RL_M1;
            end
          end
        dpb_pkg::st_wr_wait:
          if (ck_rise)
          begin
            if (lat_cnt == 4'h0)
              state <= dpb_pkg::st_wr_data;
            else
              lat_cnt <= lat_cnt - 4'h1;
          end
        dpb_pkg::st_wr_data:
          if (wr_beat)
          begin
            beat_cnt <= beat_cnt + 4'h1;
            if (beat_cnt == beat_total - 4'h1)
              state <= dpb_pkg::st_idle;
          end
        dpb_pkg::st_rd_wait:
          if (ck_rise)
          begin
            if (lat_cnt == 4'h0)
            begin
              state    <= dpb_pkg::st_rd_data;
              beat_cnt <= 4'h1;
            end
            else
              lat_cnt <= lat_cnt - 4'h1;
          end
        dpb_pkg::st_rd_data:
          if (rd_end)
            state <= dpb_pkg::st_idle;
          else if (rd_step)
            beat_cnt <= beat_cnt + 4'h1;
        default:
          state <= dpb_pkg::st_idle;
      endcase
    end
  end

  // a beat with the mask high is dropped unless the mask is off
  assign wr_keep = wr_beat && !(pin.dm && !tdqs_en);

  always_ff @(posedge ref_clk)
  begin
    if (wr_keep)
      mem[mem_idx] <= pin.dq & LANES;
  end

  // read data and strobe change together
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_out    <= 8'h00;
      dq_oe     <= 8'h00;
      dqs_out   <= 1'b0;
      dqs_n_out <= 1'b1;
      dqs_oe    <= 1'b0;
    end
    else if (reset)
    begin
      dq_out    <= 8'h00;
      dq_oe     <= 8'h00;
      dqs_out   <= 1'b0;
      dqs_n_out <= 1'b1;
      dqs_oe    <= 1'b0;
    end
    else if (rd_start)
    begin
      dq_out    <= mem[col_base] & LANES;
      dq_oe     <= LANES;
      dqs_out   <= 1'b1;
      dqs_n_out <= 1'b0;
      dqs_oe    <= 1'b1;
    end
    else if (rd_step)
    begin
      dq_out    <= mem[mem_idx] & LANES;
      dqs_out   <= ~dqs_out;
      dqs_n_out <= dqs_out;
    end
    else if (rd_end)
    begin
      dq_oe     <= 8'h00;
      dqs_out   <= 1'b0;
      dqs_n_out <= 1'b1;
      dqs_oe    <= 1'b0;
    end
  end

  // termination only while the device is not driving
  assign term_on = odt_reg && !dqs_oe;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      term_dq     <= 8'h00;
      term_dqs    <= 1'b0;
      term_dm     <= 1'b0;
      term_tdqs_n <= 1'b0;
    end
    else if (reset)
    begin
      term_dq     <= 8'h00;
      term_dqs    <= 1'b0;
      term_dm     <= 1'b0;
      term_tdqs_n <= 1'b0;
    end
    else
    begin
      term_dq     <= term_on ? LANES : 8'h00;
      term_dqs    <= term_on;
      term_dm     <= term_on;
      term_tdqs_n <= term_on && tdqs_en;
    end
  end

endmodule

// ===== dpb_ddr3_pins_sva.sv
`timescale 1ns/100ps
module dpb_ddr3_pins_sva #(
  parameter bit X8_MODE = 1'b1
) (
  // clock and resets
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       rst_n,
  // read side
  input wire logic [7:0] dq_out,
  input wire logic [7:0] dq_oe,
  input wire logic       dqs_out,
  input wire logic       dqs_n_out,
  input wire logic       dqs_oe,
  // termination
  input wire logic [7:0] term_dq,
  input wire logic       term_dqs,
  input wire logic       term_tdqs_n
);
  localparam logic [7:0] LANES = X8_MODE ? 8'hFF : 8'h0F;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // burst opens
  sequence s_burst_start;
    !dqs_oe ##1 dqs_oe;
  endsequence

  // data moves within a burst
  sequence s_beat_step;
    dqs_oe && $past(dqs_oe) && $changed(dq_out);
  endsequence

  rst_quiet_a: assert property (
    !rst_n |-> dq_oe == 8'h00 && !dqs_oe && term_dq == 8'h00)
    else $error("outputs active while reset pin low");
  lane_width_a: assert property (
    dqs_oe |-> dq_oe == LANES)
    else $error("wrong lanes driven");
  strobe_pair_a: assert property (
    dqs_oe |-> dqs_n_out == !dqs_out)
    else $error("strobe pair not complementary");
  burst_open_a: assert property (
    s_burst_start |-> (dqs_out && !dqs_n_out) ##1 dqs_oe [*7])
    else $error("burst start malformed");
  strobe_step_a: assert property (
    s_burst_start |-> ##[1:8] $changed(dqs_out))
    else $error("strobe did not toggle");
  edge_align_a: assert property (
    s_beat_step |-> $changed(dqs_out))
    else $error("data moved without strobe edge");
  term_read_a: assert property (
    dqs_oe && $past(dqs_oe) |-> term_dq == 8'h00 && !term_dqs)
    else $error("termination on while driving");
  term_lanes_a: assert property (
    term_dq != 8'h00 |-> term_dq == LANES && term_dqs)
    else $error("termination on wrong balls");
  tdqs_x8_a: assert property (
    term_tdqs_n |-> X8_MODE == 1'b1 && term_dq == LANES)
    else $error("strobe termination misused");
endmodule

// ===== dpb_host_model.sv
`timescale 1ns/100ps
module dpb_host_model #(
  parameter int unsigned WL = 5
) (
  // link clock and command
  output logic             ck,
  output dpb_pkg::dpb_ca_t ca,
  // write data
  output logic [7:0]       dq_in,
  output logic             dm_in,
  output logic             dqs_in
);
  initial
  begin
    ck = 1'b0;
    ca = '1;
    ca.odt = 1'b0;
    dq_in = 8'h00;
    dm_in = 1'b0;
    dqs_in = 1'b0;
  end

  // one ck period, pins settled before the rise
  task automatic tick();
    ck = 1'b1;
    #200;
    ck = 1'b0;
    #200;
  endtask

  task automatic issue(input logic [3:0] c, input logic [2:0] b,
                       input logic [14:0] a, input logic o);
    {ca.cs_n, ca.ras_n, ca.cas_n, ca.we_n} = c;
    ca.ba = b;
    ca.addr = a;
    ca.odt = o;
    #200;
    ck = 1'b1;
    #200;
    {ca.cs_n, ca.ras_n, ca.cas_n, ca.we_n} = 4'h7;
    ck = 1'b0;
    #200;
  endtask

  // beats centred on strobe edges
  task automatic wr_data(input int n, input logic [63:0] d,
                         input logic [7:0] m);
    int i;
    repeat (WL) tick();
    for (i = 0; i < n; i++)
    begin
      dq_in = d[8*i +: 8];
      dm_in = m[i];
      #100;
      dqs_in = ~dqs_in;
      #100;
    end
    dq_in = ~dq_in;
    dm_in = ~dm_in;
  endtask
endmodule

// ===== dpb_ddr3_pins_test.sv
`timescale 1ns/100ps
module dpb_ddr3_pins_test;
  logic             ref_clk, reset, rst_n, ck, dm_in, dqs_in;
  logic             dqs_out, dqs_n_out, dqs_oe, term_dqs, term_dm;
  logic             term_tdqs_n, dqs_q, a12;
  logic [7:0]       dq_in, dq_out, dq_oe, term_dq;
  logic [7:0]       exp_mem [64];
  logic [7:0]       rd_q [$];
  logic [14:0]      a;
  dpb_pkg::dpb_ca_t ca;
  int               failures, checks, m;

  dpb_host_model i_dpb_host_model (.ck(ck), .ca(ca), .dq_in(dq_in),
    .dm_in(dm_in), .dqs_in(dqs_in));

  dpb_ddr3_pins #(.X8_MODE(1'b1)) i_dpb_ddr3_pins (.ref_clk(ref_clk),
    .reset(reset), .rst_n(rst_n), .ck(ck), .cs_n(ca.cs_n),
    .ras_n(ca.ras_n), .cas_n(ca.cas_n), .we_n(ca.we_n), .odt(ca.odt),
    .ba(ca.ba), .addr(ca.addr), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .dm_in(dm_in), .dqs_in(dqs_in), .dqs_out(dqs_out),
    .dqs_n_out(dqs_n_out), .dqs_oe(dqs_oe), .term_dq(term_dq),
    .term_dqs(term_dqs), .term_dm(term_dm), .term_tdqs_n(term_tdqs_n));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // one entry per strobe edge seen
  always @(posedge ref_clk)
  begin
    if (dqs_oe === 1'b1 && dqs_out !== dqs_q)
      rd_q.push_back(dq_out);
    dqs_q <= (dqs_oe === 1'b1) ? dqs_out : 1'b0;
  end

  function automatic int burst_len(input int mode, input logic chop_n);
    return (mode == 2 || (mode == 1 && !chop_n)) ? 4 : 8;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic xfer(input logic [14:0] ad, input int n,
                      input logic [63:0] d, input logic [7:0] mk,
                      input bit mask_on);
    int i;
    i_dpb_host_model.issue(dpb_pkg::cmd_wr, 3'h0, ad, 1'b0);
    i_dpb_host_model.wr_data(n, d, mk);
    for (i = 0; i < n; i++)
    begin
      if (!(mk[i] && mask_on))
        exp_mem[6'(ad[5:0] + i)] = d[8*i +: 8];
    end
    rd_q.delete();
    i_dpb_host_model.issue(dpb_pkg::cmd_rd, 3'h0, ad, 1'b0);
    repeat (10) i_dpb_host_model.tick();
    check(8'(rd_q.size()), 8'(n));
    for (i = 0; i < n; i++)
      check(rd_q[i], exp_mem[6'(ad[5:0] + i)]);
  endtask

  task automatic term(input logic [14:0] mr1, input logic o,
                      input logic [7:0] w, input logic t);
    i_dpb_host_model.issue(dpb_pkg::cmd_mrs, 3'h1, mr1, o);
    i_dpb_host_model.tick();
    check(term_dq, w);
    check({7'h00, term_dm}, {7'h00, |w});
    check({7'h00, term_tdqs_n}, {7'h00, t});
  endtask

  initial
  begin
    reset = 1'b1;
    rst_n = 1'b0;
    failures = 0;
    checks = 0;
    void'($urandom(45));
    repeat (20) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    rst_n = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    check(dq_oe, 8'h00);
    term(15'h0004, 1'b1, 8'hFF, 1'b0);
    term(15'h0004, 1'b0, 8'h00, 1'b0);
    $display("test termination done");
    for (m = 0; m < 3; m++)
    begin
      i_dpb_host_model.issue(dpb_pkg::cmd_mrs, 3'h0, 15'(m), 1'b0);
      repeat (2)
      begin
        a12 = 1'($urandom);
        a = {2'h0, a12, 6'h00, 6'($urandom)};
        xfer(a, burst_len(m, a12), {$urandom, $urandom},
             8'($urandom) & 8'($urandom), 1'b1);
      end
    end
    xfer(15'h003E, 4, {$urandom, $urandom}, 8'h05, 1'b1);
    $display("test bursts done");
    rd_q.delete();
    i_dpb_host_model.issue(4'hD, 3'h0, 15'h0010, 1'b0);
    repeat (8) i_dpb_host_model.tick();
    check(8'(rd_q.size()), 8'h00);
    $display("test deselect done");
    term(15'h0000, 1'b1, 8'h00, 1'b0);
    term(15'h0840, 1'b1, 8'hFF, 1'b1);
    i_dpb_host_model.issue(dpb_pkg::cmd_mrs, 3'h0, 15'h0000, 1'b0);
    xfer(15'h0020, 8, {$urandom, $urandom}, 8'hFF, 1'b0);
    $display("test strobe termination done");
    i_dpb_host_model.issue(dpb_pkg::cmd_rd, 3'h0, 15'h0020, 1'b0);
    repeat (6) i_dpb_host_model.tick();
    rst_n = 1'b0;
    #5;
    check({7'h00, dqs_oe}, 8'h00);
    check(dq_oe, 8'h00);
    i_dpb_host_model.issue(dpb_pkg::cmd_rd, 3'h0, 15'h0020, 1'b0);
    repeat (8) i_dpb_host_model.tick();
    check({7'h00, dqs_oe}, 8'h00);
    rst_n = 1'b1;
    $display("test reset pin done");
    wrap_up();
  end

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end
endmodule

bind dpb_ddr3_pins dpb_ddr3_pins_sva #(.X8_MODE(X8_MODE))
  i_dpb_ddr3_pins_sva (.ref_clk(ref_clk), .reset(reset), .rst_n(rst_n),
  .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
  .dqs_n_out(dqs_n_out), .dqs_oe(dqs_oe), .term_dq(term_dq),
  .term_dqs(term_dqs), .term_tdqs_n(term_tdqs_n));
